// File: wcd_top.sv
// How it works
// RL1: Mode 11 runs the watchdog awake and asleep, ignoring the soft enable.
// RL2: Mode 10 counts only while awake and holds the count during sleep.
// RL3: Mode 01 runs the watchdog exactly when the soft enable bit is set.
// RL4: Mode 00 keeps the watchdog off whatever the soft enable says.
// RL5: Period code n from 0 to 18 divides by two to the power n plus five.
// RL6: The divider counts ticks of the nominal 31 kHz low-frequency source.
// RL7: Bit 7 of the configuration byte is unimplemented and reads as one.
// RL8: A blank configuration byte reads all ones: always on, code all ones.
// RL9: Period code all ones hands the period to the runtime period field.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
module wcd_top
    import wcd_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Core state
    input  wire logic        sleep_i,
    // Watchdog state
    output logic             wdt_run_o,
    output logic             wdt_count_o,
    output logic      [4:0]  wdt_period_o,
    output logic             wdt_timeout_o
);

    // Register state
    wcd_cfg_t    cfg_q;
    wcd_cfg_t    cfg_d;
    logic        sen_q;
    logic        sen_d;
    logic [4:0]  rt_ps_q;
    logic [4:0]  rt_ps_d;
    logic        tof_q;
    logic        tof_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        perr_q;
    logic        perr_d;
    logic        boot_q;

    // Decoded state
    logic        run;
    logic        hold;
    logic [4:0]  eff_code;
    logic        lf_tick;
    logic        expire;
    logic        kick;
    logic        run_q;
    logic        cnt_q;
    logic [4:0]  per_q;

    // Bus phases
    logic        setup;
    logic        wr_acc;
    logic        hit;

    assign setup  = psel_i && !penable_i;
    assign wr_acc = psel_i && penable_i && pwrite_i;
    assign hit    = (paddr_i == ADDR_CTRL) || (paddr_i == ADDR_CFG) ||
                    (paddr_i == ADDR_STAT) || (paddr_i == ADDR_KICK);

    // Clamp a reserved period code to the shortest one
    function automatic logic [4:0] clamp_code(input logic [4:0] c);
        clamp_code = (c > CODE_MAX) ? CODE_MIN : c;
    endfunction

    // Mode decode
    always_comb begin
        run  = 1'b0;
        hold = 1'b0;
        case (cfg_q.mode)
            WCD_ON: begin
                run = 1'b1; // [RL1]
            end
            WCD_AWAKE: begin
                run  = 1'b1; // [RL2]
                hold = sleep_i; // [RL2]
            end
            WCD_SOFT: begin
                run = sen_q; // [RL3]
            end
            WCD_OFF: begin
                run = 1'b0; // [RL4]
            end
            default: begin
                run = 1'b0;
            end
        endcase
        if (cfg_q.period == CODE_SW) begin
            eff_code = clamp_code(rt_ps_q); // [RL9]
        end else begin
            eff_code = clamp_code(cfg_q.period); // [RL5]
        end
    end

    assign kick = wr_acc && (paddr_i == ADDR_KICK);

    // Low-frequency tick source
    wcd_lftick u_lftick (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .tick_o  (lf_tick) // [RL6]
    );

    // Timeout divider
    wcd_div u_div (
        .mclk_i   (mclk_i),
        .rst_n_i  (rst_n_i),
        .tick_i   (lf_tick),
        .en_i     (run),
        .hold_i   (hold),
        .clr_i    (kick),
        .code_i   (eff_code),
        .expire_o (expire)
    );

    // Register next values
    always_comb begin
        cfg_d   = cfg_q;
        sen_d   = sen_q;
        rt_ps_d = rt_ps_q;
        tof_d   = tof_q;
        if (wr_acc && paddr_i == ADDR_CFG) begin
            cfg_d = wcd_cfg_t'(pwdata_i[6:0]);
        end
        if (wr_acc && paddr_i == ADDR_CTRL) begin
            sen_d   = pwdata_i[CTRL_SEN_BIT];
            rt_ps_d = pwdata_i[CTRL_PS_LSB +: 5];
        end
        if (wr_acc && paddr_i == ADDR_STAT && pwdata_i[STAT_TOF_BIT]) begin
            tof_d = 1'b0;
        end
        if (expire) begin
            tof_d = 1'b1;
        end
    end

    // Read data and error captured in the setup cycle
    always_comb begin
        prdata_d = prdata_q;
        perr_d   = perr_q;
        if (setup) begin
            prdata_d = 32'h0000_0000;
            perr_d   = !hit;
            case (paddr_i)
                ADDR_CTRL: begin
                    prdata_d[CTRL_SEN_BIT]      = sen_q;
                    prdata_d[CTRL_PS_LSB +: 5]  = rt_ps_q;
                end
                ADDR_CFG: begin
                    prdata_d[6:0]          = cfg_q;
                    prdata_d[CFG_UNIMP_BIT] = CFG_UNIMP_VAL; // [RL7]
                end
                ADDR_STAT: begin
                    prdata_d[STAT_RUN_BIT]      = run;
                    prdata_d[STAT_CNT_BIT]      = run && !hold;
                    prdata_d[STAT_PS_LSB +: 5]  = eff_code;
                    prdata_d[STAT_TOF_BIT]      = tof_q;
                end
                default: begin
                    prdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_q    <= CFG_RST; // [RL8]
            sen_q    <= SEN_RST;
            rt_ps_q  <= RT_PERIOD_RST; // [RL9]
            tof_q    <= 1'b0;
            prdata_q <= 32'h0000_0000;
            perr_q   <= 1'b0;
            boot_q   <= 1'b0;
            run_q    <= 1'b0;
            cnt_q    <= 1'b0;
            per_q    <= 5'h00;
        end else begin
            cfg_q    <= cfg_d;
            sen_q    <= sen_d;
            rt_ps_q  <= rt_ps_d;
            tof_q    <= tof_d;
            prdata_q <= prdata_d;
            perr_q   <= perr_d;
            boot_q   <= 1'b1;
            run_q    <= run;
            cnt_q    <= run && !hold;
            per_q    <= eff_code;
        end
    end

    // Outputs
    assign prdata_o      = prdata_q;
    assign pready_o      = 1'b1;
    assign pslverr_o     = psel_i && penable_i && perr_q;
    assign wdt_run_o     = run_q;
    assign wdt_count_o   = cnt_q;
    assign wdt_period_o  = per_q;
    assign wdt_timeout_o = expire;

    // Checks
    AST_ALWAYS_ON: assert property ( // [RL1]
        @(posedge mclk_i) disable iff (!rst_n_i)
        cfg_q.mode == WCD_ON |=> wdt_run_o && wdt_count_o)
        else $error("Mode 11 did not run continuously");

    AST_AWAKE_RUN: assert property ( // [RL2]
        @(posedge mclk_i) disable iff (!rst_n_i)
        cfg_q.mode == WCD_AWAKE && !sleep_i |=> wdt_count_o)
        else $error("Mode 10 not counting while awake");

    AST_SLEEP_HOLD: assert property ( // [RL2]
        @(posedge mclk_i) disable iff (!rst_n_i)
        cfg_q.mode == WCD_AWAKE && sleep_i |=> wdt_run_o && !wdt_count_o)
        else $error("Mode 10 counting during sleep");

    AST_SOFT_CTRL: assert property ( // [RL3]
        @(posedge mclk_i) disable iff (!rst_n_i)
        cfg_q.mode == WCD_SOFT |=> wdt_run_o == $past(sen_q))
        else $error("Mode 01 not following soft enable");

    AST_OFF: assert property ( // [RL4]
        @(posedge mclk_i) disable iff (!rst_n_i)
        cfg_q.mode == WCD_OFF |=> !wdt_run_o && !wdt_timeout_o ##1 !wdt_timeout_o)
        else $error("Mode 00 watchdog active");

    AST_PERIOD_CODE: assert property ( // [RL5]
        @(posedge mclk_i) disable iff (!rst_n_i)
        cfg_q.period <= CODE_MAX |=> wdt_period_o == $past(cfg_q.period))
        else $error("Period code not applied");

    AST_SW_PERIOD: assert property ( // [RL9]
        @(posedge mclk_i) disable iff (!rst_n_i)
        cfg_q.period == CODE_SW && rt_ps_q <= CODE_MAX
        |=> wdt_period_o == $past(rt_ps_q))
        else $error("Runtime period not applied");

    AST_UNIMP_ONE: assert property ( // [RL7]
        @(posedge mclk_i) disable iff (!rst_n_i)
        setup && !pwrite_i && paddr_i == ADDR_CFG |=> prdata_o[7])
        else $error("Configuration bit 7 read as zero");

    AST_BLANK: assert property ( // [RL8]
        @(posedge mclk_i) disable iff (!rst_n_i)
        !boot_q |-> cfg_q == CFG_RST && rt_ps_q == RT_PERIOD_RST)
        else $error("Blank configuration not all ones");

    AST_TOF_SET: assert property ( // [RL5]
        @(posedge mclk_i) disable iff (!rst_n_i)
        expire |=> tof_q)
        else $error("Timeout flag lost");

    AST_CODE_RANGE: assert property ( // [RL5]
        @(posedge mclk_i) disable iff (!rst_n_i)
        wdt_period_o <= CODE_MAX)
        else $error("Effective period code out of range");

    AST_RSVD_CODE: assert property ( // [RL5]
        @(posedge mclk_i) disable iff (!rst_n_i)
        cfg_q.period > CODE_MAX && cfg_q.period != CODE_SW
        |=> wdt_period_o == CODE_MIN)
        else $error("Reserved period code not shortest");

    AST_SW_RSVD: assert property ( // [RL9]
        @(posedge mclk_i) disable iff (!rst_n_i)
        cfg_q.period == CODE_SW && rt_ps_q > CODE_MAX
        |=> wdt_period_o == CODE_MIN)
        else $error("Reserved runtime code not shortest");

    AST_SLEEP_QUIET: assert property ( // [RL2]
        @(posedge mclk_i) disable iff (!rst_n_i)
        cfg_q.mode == WCD_AWAKE && sleep_i |=> !wdt_timeout_o)
        else $error("Mode 10 timed out during sleep");

    AST_SOFT_QUIET: assert property ( // [RL3]
        @(posedge mclk_i) disable iff (!rst_n_i)
        cfg_q.mode == WCD_SOFT && !sen_q |=> !wdt_timeout_o)
        else $error("Mode 01 timed out with soft enable clear");

    AST_CTRL_READ: assert property ( // [RL9]
        @(posedge mclk_i) disable iff (!rst_n_i)
        setup && !pwrite_i && paddr_i == ADDR_CTRL
        |=> prdata_o[CTRL_PS_LSB +: 5] == $past(rt_ps_q))
        else $error("Runtime period field read back wrong");

    AST_CFG_READ: assert property ( // [RL8]
        @(posedge mclk_i) disable iff (!rst_n_i)
        setup && !pwrite_i && paddr_i == ADDR_CFG
        |=> prdata_o[6:0] == $past(cfg_q))
        else $error("Configuration byte read back wrong");

    AST_BLANK_OUT: assert property ( // [RL8]
        @(posedge mclk_i) disable iff (!rst_n_i)
        boot_q && !$past(boot_q)
        |-> wdt_run_o && wdt_count_o && wdt_period_o == RT_PERIOD_RST)
        else $error("Blank configuration outputs wrong after reset");

endmodule

// File: wcd_pkg.sv
package wcd_pkg;

    // Core clock and low-frequency source timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned LF_PERIOD_NS  = 32258;
    localparam int unsigned LF_DIV_CYC    = LF_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [11:0] LF_DIV_LAST   = 12'(LF_DIV_CYC - 1);

    // Register byte addresses
    localparam logic [31:0] ADDR_CTRL = 32'h0030_0000;
    localparam logic [31:0] ADDR_CFG  = 32'h0030_0004;
    localparam logic [31:0] ADDR_STAT = 32'h0030_0008;
    localparam logic [31:0] ADDR_KICK = 32'h0030_000C;

    // Field positions
    localparam int unsigned CFG_UNIMP_BIT = 7;
    localparam int unsigned CTRL_SEN_BIT  = 0;
    localparam int unsigned CTRL_PS_LSB   = 1;
    localparam int unsigned STAT_RUN_BIT  = 0;
    localparam int unsigned STAT_CNT_BIT  = 1;
    localparam int unsigned STAT_PS_LSB   = 2;
    localparam int unsigned STAT_TOF_BIT  = 7;

    // Period codes
    localparam logic [4:0] CODE_MIN  = 5'h00;
    localparam logic [4:0] CODE_MAX  = 5'h12;
    localparam logic [4:0] CODE_SW   = 5'h1F;
    localparam logic [4:0] EXP_BASE  = 5'h05;

    typedef enum logic [1:0] {
        WCD_OFF   = 2'b00,
        WCD_SOFT  = 2'b01,
        WCD_AWAKE = 2'b10,
        WCD_ON    = 2'b11
    } wcd_mode_t;

    typedef struct packed {
        wcd_mode_t  mode;
        logic [4:0] period;
    } wcd_cfg_t;

    // Values after reset
    localparam wcd_cfg_t   CFG_RST       = '{mode: WCD_ON, period: 5'h1F};
    localparam logic       SEN_RST       = 1'b0;
    localparam logic [4:0] RT_PERIOD_RST = 5'h0B;
    localparam logic       CFG_UNIMP_VAL = 1'b1;

endpackage

// File: wcd_lftick.sv
`timescale 1ns/1ns
module wcd_lftick
    import wcd_pkg::*;
(
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    // Low-frequency tick
    output logic      tick_o
);

    logic [11:0] cnt_q;
    logic [11:0] cnt_d;
    logic        tick_q;
    logic        tick_d;

    always_comb begin
        tick_d = (cnt_q == LF_DIV_LAST);
        cnt_d  = tick_d ? 12'h000 : cnt_q + 12'h001;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q  <= 12'h000;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;

    AST_LF_RATE: assert property ( // [RL6]
        @(posedge mclk_i) disable iff (!rst_n_i)
        tick_q |-> $past(cnt_q) == LF_DIV_LAST)
        else $error("Low-frequency tick off its period");

endmodule

// File: wcd_div.sv
`timescale 1ns/1ns
module wcd_div
    import wcd_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // Control
    input  wire logic       tick_i,
    input  wire logic       en_i,
    input  wire logic       hold_i,
    input  wire logic       clr_i,
    input  wire logic [4:0] code_i,
    // Result
    output logic            expire_o
);

    logic [22:0] cnt_q;
    logic [22:0] cnt_d;
    logic [22:0] last;
    logic        exp_q;
    logic        exp_d;

    always_comb begin
        last  = 23'((24'h000001 << (code_i + EXP_BASE)) - 24'h000001); // [RL5]
        exp_d = 1'b0;
        cnt_d = cnt_q;
        if (!en_i || clr_i) begin
            cnt_d = 23'h000000;
        end else if (tick_i && !hold_i) begin // [RL2]
            if (cnt_q >= last) begin
                cnt_d = 23'h000000;
                exp_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 23'h000001;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 23'h000000;
            exp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end

    assign expire_o = exp_q;

    AST_DIV_HOLD: assert property ( // [RL2]
        @(posedge mclk_i) disable iff (!rst_n_i)
        en_i && hold_i && !clr_i |=> cnt_q == $past(cnt_q))
        else $error("Count moved while suspended");

endmodule

// File: wcd_top_tb.sv
`timescale 1ns/1ns
module wcd_top_tb
    import wcd_pkg::*;
;
    logic        mclk_i;
    logic        rst_n_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [31:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        sleep_i;
    logic        wdt_run_o;
    logic        wdt_count_o;
    logic [4:0]  wdt_period_o;
    logic        wdt_timeout_o;
    int          n_errors;
    int          tests_run;
    int          cyc;
    logic [31:0] rd;
    logic        err;
    logic        ex_run;
    logic        ex_cnt;
    logic [4:0]  ex_per;
    localparam int TO_LIMIT = int'(32 * LF_DIV_CYC + 8);

    wcd_top dut_u (
        .mclk_i        (mclk_i),
        .rst_n_i       (rst_n_i),
        .psel_i        (psel_i),
        .penable_i     (penable_i),
        .pwrite_i      (pwrite_i),
        .paddr_i       (paddr_i),
        .pwdata_i      (pwdata_i),
        .prdata_o      (prdata_o),
        .pready_o      (pready_o),
        .pslverr_o     (pslverr_o),
        .sleep_i       (sleep_i),
        .wdt_run_o     (wdt_run_o),
        .wdt_count_o   (wdt_count_o),
        .wdt_period_o  (wdt_period_o),
        .wdt_timeout_o (wdt_timeout_o)
    );

    always #5 mclk_i = ~mclk_i;

    task automatic wrap_up();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd);
        int i;
        @(posedge mclk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= wd;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk_i);
            if (pready_o === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            wrap_up();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic settle();
        repeat (3) @(posedge mclk_i);
        #1;
    endtask

    task automatic chk_out(input logic r, input logic c);
        chk("run", wdt_run_o, r);
        chk("count", wdt_count_o, c);
    endtask

    initial begin
        mclk_i = 1'b0;
        rst_n_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 32'h0;
        pwdata_i = 32'h0;
        sleep_i = 1'b0;
        n_errors = 0;
        tests_run = 0;
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        // Blank device state after reset
        settle();
        chk_out(1'b1, 1'b1);
        chk("period_rst", wdt_period_o, 5'h0B);
        apb(1'b0, ADDR_CFG, 32'h0);
        chk("cfg_rst", rd, 32'h0000_00FF);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl_rst", rd, 32'h0000_0016);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("stat_rst", rd, 32'h0000_002F);
        apb(1'b0, 32'h0030_0010, 32'h0);
        chk("unmapped_err", err, 1'b1);
        chk("unmapped_rd", rd, 32'h0);
        // Unimplemented top bit reads one after writing zero
        apb(1'b1, ADDR_CFG, 32'h0000_0001);
        apb(1'b0, ADDR_CFG, 32'h0);
        chk("cfg_bit7", rd, 32'h0000_0081);
        // Every mode against soft enable and sleep
        for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 4; s++) begin
                apb(1'b1, ADDR_CTRL, {26'h0, 5'h0B, s[0]});
                apb(1'b1, ADDR_CFG, {25'h0, m[1:0], 5'h01});
                sleep_i <= s[1];
                settle();
                ex_run = m[1] | (m[0] & s[0]);
                ex_cnt = ex_run & ~(m == 2 && s[1]);
                chk_out(ex_run, ex_cnt);
            end
        end
        sleep_i <= 1'b0;
        // Every period code, runtime field set to 5
        apb(1'b1, ADDR_CTRL, 32'h0000_000A);
        for (int n = 0; n < 32; n++) begin
            apb(1'b1, ADDR_CFG, {25'h0, 2'b11, n[4:0]});
            settle();
            ex_per = (n <= 18) ? n[4:0] : ((n == 31) ? 5'h05 : 5'h00);
            chk("period", wdt_period_o, ex_per);
        end
        // Reserved runtime code falls back to the shortest period
        apb(1'b1, ADDR_CTRL, 32'h0000_0026);
        settle();
        chk("period_rt_rsvd", wdt_period_o, 5'h00);
        // Shortest timeout: 32 low-frequency ticks after a kick
        apb(1'b1, ADDR_CFG, 32'h0000_0060);
        apb(1'b1, ADDR_KICK, 32'h0000_0001);
        for (cyc = 0; cyc < TO_LIMIT; cyc++) begin
            @(posedge mclk_i);
            #1;
            if (wdt_timeout_o === 1'b1) break;
        end
        if (cyc == TO_LIMIT) begin
            n_errors++;
            wrap_up();
        end
        chk("to_early", cyc >= 31 * LF_DIV_CYC - 2, 1'b1);
        chk("to_late", cyc <= 32 * LF_DIV_CYC + 4, 1'b1);
        @(posedge mclk_i);
        #1;
        chk("to_pulse", wdt_timeout_o, 1'b0);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("stat_to", rd, 32'h0000_0083);
        apb(1'b1, ADDR_STAT, 32'h0000_0080);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("stat_clr", rd, 32'h0000_0003);
        wrap_up();
    end
endmodule
